// ---- design/cmg_pkg.sv ----
// shared constants and types for the cpu mode memory guard
package cmg_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // memory map, byte sizes
    localparam int KBYTE           = 1024;
    localparam int ROM_APP_BYTES   = 160 * KBYTE;
    localparam int ROM_TEST_BYTES  = 24 * KBYTE;
    localparam int EE_BYTES        = 24 * KBYTE;
    localparam int EE_RSV_BYTES    = 128;
    localparam int RAM_GP_BYTES    = 3584;
    localparam int RAM_COP_BYTES   = 2560;
    localparam int NUM_SYS_VECTORS = 32;

    localparam int ADDR_W = 18;
    localparam int SFR_GROUP_LSB = 5;
    localparam int SFR_GROUP_W   = 3;

    // region bounds, inclusive
    localparam logic [ADDR_W-1:0] ROM_APP_LO  = 18'h00000;
    localparam logic [ADDR_W-1:0] ROM_APP_HI  = ADDR_W'(ROM_APP_BYTES - 1);
    localparam logic [ADDR_W-1:0] ROM_TEST_LO = ADDR_W'(ROM_APP_BYTES);
    localparam logic [ADDR_W-1:0] ROM_TEST_HI = ADDR_W'(ROM_APP_BYTES + ROM_TEST_BYTES - 1);
    localparam logic [ADDR_W-1:0] EE_RSV_LO   = 18'h00000;
    localparam logic [ADDR_W-1:0] EE_RSV_HI   = ADDR_W'(EE_RSV_BYTES - 1);
    localparam logic [ADDR_W-1:0] EE_APP_LO   = ADDR_W'(EE_RSV_BYTES);
    localparam logic [ADDR_W-1:0] EE_APP_HI   = ADDR_W'(EE_BYTES - 1);
    localparam logic [ADDR_W-1:0] RAM_GP_LO   = 18'h00000;
    localparam logic [ADDR_W-1:0] RAM_GP_HI   = ADDR_W'(RAM_GP_BYTES - 1);
    localparam logic [ADDR_W-1:0] RAM_COP_LO  = ADDR_W'(RAM_GP_BYTES);
    localparam logic [ADDR_W-1:0] RAM_COP_HI  = ADDR_W'(RAM_GP_BYTES + RAM_COP_BYTES - 1);

    // vector table in application rom
    localparam logic [ADDR_W-1:0] VEC_EXC_BASE = 18'h00000;
    localparam logic [ADDR_W-1:0] VEC_IRQ_BASE = 18'h00100;
    localparam logic [ADDR_W-1:0] VEC_SYS_BASE = 18'h00200;
    localparam int                VEC_SHIFT    = 3;
    localparam logic [4:0]        VEC_IDX_VIOL = 5'h00;

    // user restriction configuration selectors
    localparam logic [2:0] CFG_SFR_GRANT = 3'h0;
    localparam logic [2:0] CFG_RAM_LO    = 3'h1;
    localparam logic [2:0] CFG_RAM_HI    = 3'h2;
    localparam logic [2:0] CFG_EE_LO     = 3'h3;
    localparam logic [2:0] CFG_EE_HI     = 3'h4;

    // submode select values
    localparam logic [1:0] SS_SEL_BOOT   = 2'h0;
    localparam logic [1:0] SS_SEL_TEST   = 2'h1;
    localparam logic [1:0] SS_SEL_COMPAT = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [4:0] {
        MODE_BOOT   = 5'h01,
        MODE_TEST   = 5'h02,
        MODE_COMPAT = 5'h04,
        MODE_SYSTEM = 5'h08,
        MODE_USER   = 5'h10
    } cmg_mode_t;

    typedef enum logic [1:0] {
        SPACE_ROM = 2'h0,
        SPACE_EE  = 2'h1,
        SPACE_RAM = 2'h2,
        SPACE_SFR = 2'h3
    } cmg_space_t;

    typedef enum logic [1:0] {
        VEC_EXC = 2'h0,
        VEC_IRQ = 2'h1,
        VEC_SYS = 2'h2
    } cmg_vec_kind_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        cmg_space_t        space;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } cmg_access_t;

    typedef struct packed {
        logic          valid;
        cmg_vec_kind_t kind;
        logic [4:0]    index;
    } cmg_vec_req_t;

    typedef struct packed {
        logic              valid;
        logic [2:0]        sel;
        logic [ADDR_W-1:0] data;
    } cmg_cfg_t;

endpackage : cmg_pkg

// ---- design/cmg_range_check.sv ----
// inclusive address window compare
`timescale 1ns/1ps

module cmg_range_check #(
    parameter int ADDR_W = 18
) (
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [ADDR_W-1:0] lo,
    input  wire logic [ADDR_W-1:0] hi,
    output logic                   hit
);

    assign hit = (addr >= lo) && (addr <= hi);

endmodule : cmg_range_check

// ---- design/cmg_mode_guard.sv ----
// cpu privilege mode tracker and memory access guard
`timescale 1ns/1ps

module cmg_mode_guard #(
    parameter logic [31:0]               EXC_USER_MASK   = 32'h00000000,
    parameter logic [31:0]               IRQ_USER_MASK   = 32'h00000000,
    parameter logic [(1<<cmg_pkg::SFR_GROUP_W)-1:0] USER_SFR_BASE = 8'h01,
    parameter logic [cmg_pkg::ADDR_W-1:0] BOOT_RAM_LO    = 18'h00000,
    parameter logic [cmg_pkg::ADDR_W-1:0] BOOT_RAM_HI    = 18'h0003f
) (
    input  wire logic                         ref_clk,
    input  wire logic                         reset,
    input  wire logic                         test_fuse_blown,
    input  wire logic                         boot_done,
    input  wire logic                         ss_sel_we,
    input  wire logic [1:0]                   ss_sel_val,
    input  wire logic                         ss_exit,
    input  wire logic                         drop_to_user,
    input  wire cmg_pkg::cmg_vec_req_t        vec_req,
    input  wire cmg_pkg::cmg_cfg_t            cfg,
    input  wire cmg_pkg::cmg_access_t         cpu_req,
    input  wire cmg_pkg::cmg_access_t         cop_req,
    input  wire logic [7:0]                   mem_rdata,
    output cmg_pkg::cmg_mode_t                mode,
    output logic                              vec_jump,
    output logic [cmg_pkg::ADDR_W-1:0]        vec_addr,
    output logic                              cpu_grant,
    output logic                              cop_grant,
    output cmg_pkg::cmg_access_t              mem_cmd,
    output logic                              mem_from_cop,
    output logic [7:0]                        cpu_rdata,
    output logic [7:0]                        cop_rdata,
    output logic                              viol_exc
);

    localparam int AW = cmg_pkg::ADDR_W;
    localparam int NG = 1 << cmg_pkg::SFR_GROUP_W;

    ////////////////////////////////////////////////////////////////////////////////
    // test fuse synchroniser
    logic fuse_s1;
    logic fuse_s2;
    logic fuse_s3;
    logic test_disabled;

    always_ff @(posedge ref_clk)
    begin
        fuse_s1 <= test_fuse_blown;
        fuse_s2 <= fuse_s1;
        fuse_s3 <= fuse_s2;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            test_disabled <= 1'b1;
        else if (fuse_s2 == fuse_s3)
            test_disabled <= fuse_s3;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // region decode
    logic [AW-1:0] user_ram_lo;
    logic [AW-1:0] user_ram_hi;
    logic [AW-1:0] user_ee_lo;
    logic [AW-1:0] user_ee_hi;
    logic [NG-1:0] user_sfr_grant;

    logic c_rom_app;
    logic c_rom_test;
    logic c_ee_rsv;
    logic c_ee_app;
    logic c_ram_gp;
    logic c_ram_cop;
    logic c_boot_ram;
    logic c_user_ram;
    logic c_user_ee;
    logic p_ee_app;
    logic p_ram_cop;

    cmg_range_check #(.ADDR_W(AW)) u_rom_app (.addr(cpu_req.addr), .lo(cmg_pkg::ROM_APP_LO),
        .hi(cmg_pkg::ROM_APP_HI), .hit(c_rom_app));
    cmg_range_check #(.ADDR_W(AW)) u_rom_test (.addr(cpu_req.addr), .lo(cmg_pkg::ROM_TEST_LO),
        .hi(cmg_pkg::ROM_TEST_HI), .hit(c_rom_test));
    cmg_range_check #(.ADDR_W(AW)) u_ee_rsv (.addr(cpu_req.addr), .lo(cmg_pkg::EE_RSV_LO),
        .hi(cmg_pkg::EE_RSV_HI), .hit(c_ee_rsv));
    cmg_range_check #(.ADDR_W(AW)) u_ee_app (.addr(cpu_req.addr), .lo(cmg_pkg::EE_APP_LO),
        .hi(cmg_pkg::EE_APP_HI), .hit(c_ee_app));
    cmg_range_check #(.ADDR_W(AW)) u_ram_gp (.addr(cpu_req.addr), .lo(cmg_pkg::RAM_GP_LO),
        .hi(cmg_pkg::RAM_GP_HI), .hit(c_ram_gp));
    cmg_range_check #(.ADDR_W(AW)) u_ram_cop (.addr(cpu_req.addr), .lo(cmg_pkg::RAM_COP_LO),
        .hi(cmg_pkg::RAM_COP_HI), .hit(c_ram_cop));
    cmg_range_check #(.ADDR_W(AW)) u_boot_ram (.addr(cpu_req.addr), .lo(BOOT_RAM_LO),
        .hi(BOOT_RAM_HI), .hit(c_boot_ram));
    cmg_range_check #(.ADDR_W(AW)) u_user_ram (.addr(cpu_req.addr), .lo(user_ram_lo),
        .hi(user_ram_hi), .hit(c_user_ram));
    cmg_range_check #(.ADDR_W(AW)) u_user_ee (.addr(cpu_req.addr), .lo(user_ee_lo),
        .hi(user_ee_hi), .hit(c_user_ee));
    cmg_range_check #(.ADDR_W(AW)) u_cop_ee (.addr(cop_req.addr), .lo(cmg_pkg::EE_APP_LO),
        .hi(cmg_pkg::EE_APP_HI), .hit(p_ee_app));
    cmg_range_check #(.ADDR_W(AW)) u_cop_ram (.addr(cop_req.addr), .lo(cmg_pkg::RAM_COP_LO),
        .hi(cmg_pkg::RAM_COP_HI), .hit(p_ram_cop));

    ////////////////////////////////////////////////////////////////////////////////
    // cpu access rights per mode, coprocessor access rights
    logic                            cpu_ok;
    logic [cmg_pkg::SFR_GROUP_W-1:0] sfr_group;

    assign sfr_group = cpu_req.addr[cmg_pkg::SFR_GROUP_LSB +: cmg_pkg::SFR_GROUP_W];

    always_comb
    begin
        cpu_ok = 1'b0;
        case (mode)
            cmg_pkg::MODE_TEST:
                cpu_ok = (cpu_req.space == cmg_pkg::SPACE_SFR)
                       || c_rom_app || c_rom_test || c_ee_rsv || c_ee_app
                       || c_ram_gp || c_ram_cop;
            cmg_pkg::MODE_BOOT, cmg_pkg::MODE_COMPAT:
                case (cpu_req.space)
                    cmg_pkg::SPACE_ROM: cpu_ok = c_rom_test;
                    cmg_pkg::SPACE_EE:  cpu_ok = c_ee_rsv;
                    cmg_pkg::SPACE_RAM: cpu_ok = (mode == cmg_pkg::MODE_BOOT) ? c_boot_ram
                                                 : (c_ram_gp || c_ram_cop);
                    default:            cpu_ok = 1'b1;
                endcase
            cmg_pkg::MODE_SYSTEM:
                case (cpu_req.space)
                    cmg_pkg::SPACE_ROM: cpu_ok = c_rom_app;
                    cmg_pkg::SPACE_EE:  cpu_ok = c_ee_app;
                    cmg_pkg::SPACE_RAM: cpu_ok = c_ram_gp || c_ram_cop;
                    default:            cpu_ok = 1'b1;
                endcase
            cmg_pkg::MODE_USER:
                case (cpu_req.space)
                    cmg_pkg::SPACE_ROM: cpu_ok = c_rom_app;
                    cmg_pkg::SPACE_EE:  cpu_ok = c_ee_app && c_user_ee;
                    cmg_pkg::SPACE_RAM: cpu_ok = (c_ram_gp || c_ram_cop) && c_user_ram;
                    default:            cpu_ok = USER_SFR_BASE[sfr_group]
                                                 || user_sfr_grant[sfr_group];
                endcase
            default:
                cpu_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        case (cop_req.space)
            cmg_pkg::SPACE_EE:  cop_grant = cop_req.valid && p_ee_app;
            cmg_pkg::SPACE_RAM: cop_grant = cop_req.valid && p_ram_cop;
            default:            cop_grant = 1'b0;
        endcase
    end

    assign cpu_grant = cpu_req.valid && cpu_ok;

    logic cpu_denied;
    assign cpu_denied = cpu_req.valid && !cpu_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // user restriction configuration
    logic cfg_ok;
    assign cfg_ok = cfg.valid && (mode == cmg_pkg::MODE_SYSTEM);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            user_sfr_grant <= '0;
            user_ram_lo    <= cmg_pkg::RAM_GP_LO;
            user_ram_hi    <= cmg_pkg::RAM_GP_LO;
            user_ee_lo     <= cmg_pkg::EE_APP_LO;
            user_ee_hi     <= cmg_pkg::EE_APP_LO;
        end
        else if (cfg_ok)
        begin
            case (cfg.sel)
                cmg_pkg::CFG_SFR_GRANT: user_sfr_grant <= cfg.data[NG-1:0];
                cmg_pkg::CFG_RAM_LO:    user_ram_lo    <= cfg.data;
                cmg_pkg::CFG_RAM_HI:    user_ram_hi    <= cfg.data;
                cmg_pkg::CFG_EE_LO:     user_ee_lo     <= cfg.data;
                cmg_pkg::CFG_EE_HI:     user_ee_hi     <= cfg.data;
                default:                user_sfr_grant <= user_sfr_grant;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode state and vectors
    cmg_pkg::cmg_mode_t next_mode;
    logic               in_super;
    logic               vec_take;
    logic               force_user;
    logic [AW-1:0]      next_vec_addr;

    assign in_super = (mode == cmg_pkg::MODE_BOOT) || (mode == cmg_pkg::MODE_TEST)
                   || (mode == cmg_pkg::MODE_COMPAT);
    // firmware of the super submodes is never interrupted
    assign vec_take = !in_super && (cpu_denied || vec_req.valid);

    always_comb
    begin
        force_user    = 1'b0;
        next_vec_addr = cmg_pkg::VEC_EXC_BASE
                      + AW'({cmg_pkg::VEC_IDX_VIOL, cmg_pkg::VEC_SHIFT'(0)});
        if (!cpu_denied)
        begin
            case (vec_req.kind)
                cmg_pkg::VEC_EXC:
                begin
                    force_user    = EXC_USER_MASK[vec_req.index];
                    next_vec_addr = cmg_pkg::VEC_EXC_BASE
                                  + AW'({vec_req.index, cmg_pkg::VEC_SHIFT'(0)});
                end
                cmg_pkg::VEC_IRQ:
                begin
                    force_user    = IRQ_USER_MASK[vec_req.index];
                    next_vec_addr = cmg_pkg::VEC_IRQ_BASE
                                  + AW'({vec_req.index, cmg_pkg::VEC_SHIFT'(0)});
                end
                default:
                    next_vec_addr = cmg_pkg::VEC_SYS_BASE
                                  + AW'({vec_req.index, cmg_pkg::VEC_SHIFT'(0)});
            endcase
        end
    end

    always_comb
    begin
        next_mode = mode;
        case (mode)
            cmg_pkg::MODE_BOOT:
                if (boot_done)
                    next_mode = test_disabled ? cmg_pkg::MODE_SYSTEM : cmg_pkg::MODE_TEST;
                else if (ss_sel_we && ss_sel_val == cmg_pkg::SS_SEL_COMPAT)
                    next_mode = cmg_pkg::MODE_COMPAT;
                else if (ss_sel_we && ss_sel_val == cmg_pkg::SS_SEL_TEST && !test_disabled)
                    next_mode = cmg_pkg::MODE_TEST;
            cmg_pkg::MODE_TEST, cmg_pkg::MODE_COMPAT:
                if (mode == cmg_pkg::MODE_TEST && test_disabled)
                    next_mode = cmg_pkg::MODE_SYSTEM;
                else if (ss_exit)
                    next_mode = cmg_pkg::MODE_SYSTEM;
                else if (ss_sel_we && ss_sel_val == cmg_pkg::SS_SEL_BOOT)
                    next_mode = cmg_pkg::MODE_BOOT;
                else if (ss_sel_we && ss_sel_val == cmg_pkg::SS_SEL_COMPAT)
                    next_mode = cmg_pkg::MODE_COMPAT;
                else if (ss_sel_we && ss_sel_val == cmg_pkg::SS_SEL_TEST && !test_disabled)
                    next_mode = cmg_pkg::MODE_TEST;
            cmg_pkg::MODE_SYSTEM, cmg_pkg::MODE_USER:
                if (vec_take)
                    next_mode = force_user ? cmg_pkg::MODE_USER : cmg_pkg::MODE_SYSTEM;
                else if (drop_to_user && mode == cmg_pkg::MODE_SYSTEM)
                    next_mode = cmg_pkg::MODE_USER;
            default:
                next_mode = cmg_pkg::MODE_BOOT;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            mode <= cmg_pkg::MODE_BOOT;
        else
            mode <= next_mode;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            vec_jump <= 1'b0;
            vec_addr <= cmg_pkg::VEC_EXC_BASE;
        end
        else
        begin
            vec_jump <= vec_take;
            if (vec_take)
                vec_addr <= next_vec_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // memory command and read data
    logic grant_cpu_q;
    logic grant_cop_q;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            mem_cmd      <= '0;
            mem_from_cop <= 1'b0;
            viol_exc     <= 1'b0;
            grant_cpu_q  <= 1'b0;
            grant_cop_q  <= 1'b0;
        end
        else
        begin
            viol_exc     <= cpu_denied;
            grant_cpu_q  <= cpu_grant;
            grant_cop_q  <= cop_grant && !cpu_grant;
            mem_from_cop <= cop_grant && !cpu_grant;
            if (cpu_grant)
                mem_cmd <= cpu_req;
            else if (cop_grant)
                mem_cmd <= cop_req;
            else
                mem_cmd <= '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cpu_rdata <= 8'h00;
            cop_rdata <= 8'h00;
        end
        else
        begin
            cpu_rdata <= grant_cpu_q ? mem_rdata : 8'h00;
            cop_rdata <= grant_cop_q ? mem_rdata : 8'h00;
        end
    end

endmodule : cmg_mode_guard

// ---- verif/cmg_mem_model.sv ----
// memory array stand-in that answers the guard's granted commands
`timescale 1ns/1ps
module cmg_mem_model (
    input  wire logic                 ref_clk,
    input  wire cmg_pkg::cmg_access_t mem_cmd,
    output logic [7:0]                mem_rdata
);
    logic [7:0] last;

    // idle cycles show a moving pattern, never stale data
    assign mem_rdata = mem_cmd.valid ? (mem_cmd.addr[7:0] ^ 8'h5a) : ~last;

    always_ff @(posedge ref_clk)
    begin
        last <= mem_rdata;
    end
endmodule : cmg_mem_model

// ---- verif/cmg_guard_assertions.sv ----
// concurrent checks on the mode guard ports
`timescale 1ns/1ps
module cmg_checker (
    input wire logic                  ref_clk,
    input wire logic                  reset,
    input wire logic                  boot_done,
    input wire logic                  ss_sel_we,
    input wire cmg_pkg::cmg_vec_req_t vec_req,
    input wire cmg_pkg::cmg_access_t  cpu_req,
    input wire cmg_pkg::cmg_access_t  cop_req,
    input wire logic [7:0]            mem_rdata,
    input wire cmg_pkg::cmg_mode_t    mode,
    input wire logic                  vec_jump,
    input wire logic [17:0]           vec_addr,
    input wire logic                  cpu_grant,
    input wire logic                  cop_grant,
    input wire cmg_pkg::cmg_access_t  mem_cmd,
    input wire logic                  mem_from_cop,
    input wire logic [7:0]            cpu_rdata,
    input wire logic                  viol_exc
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_mode_onehot: assert property ($onehot(mode))
        else $error("mode not one-hot");
    a_reset_boot: assert property ($fell(reset) |-> mode == cmg_pkg::MODE_BOOT)
        else $error("no boot mode after reset");
    a_boot_exit: assert property (mode == cmg_pkg::MODE_BOOT && boot_done && !ss_sel_we
        |=> mode == cmg_pkg::MODE_TEST || mode == cmg_pkg::MODE_SYSTEM)
        else $error("boot end went to wrong mode");
    a_viol_pulse: assert property (cpu_req.valid && !cpu_grant |=> viol_exc)
        else $error("denied access raised no exception");
    a_deny_quiet: assert property (cpu_req.valid && !cpu_grant
        |=> !(mem_cmd.valid && !mem_from_cop) ##1 cpu_rdata == 8'h00)
        else $error("denied access reached memory");
    a_grant_data: assert property (cpu_req.valid && cpu_grant
        |=> mem_cmd.addr == $past(cpu_req.addr) ##1 cpu_rdata == $past(mem_rdata))
        else $error("granted read data wrong");
    a_deny_vector: assert property (cpu_req.valid && !cpu_grant
        && (mode == cmg_pkg::MODE_SYSTEM || mode == cmg_pkg::MODE_USER)
        |=> vec_jump && vec_addr == cmg_pkg::VEC_EXC_BASE && mode == cmg_pkg::MODE_SYSTEM)
        else $error("violation vector wrong");
    a_syscall_entry: assert property (vec_req.valid && vec_req.kind == cmg_pkg::VEC_SYS
        && mode == cmg_pkg::MODE_USER && !cpu_req.valid
        |=> mode == cmg_pkg::MODE_SYSTEM && vec_jump
        && vec_addr == cmg_pkg::VEC_SYS_BASE + 18'($past(vec_req.index)) * 18'h8)
        else $error("system call entry wrong");
    a_ee_reserve: assert property (cpu_req.valid && cpu_req.space == cmg_pkg::SPACE_EE
        && cpu_req.addr <= cmg_pkg::EE_RSV_HI
        && (mode == cmg_pkg::MODE_SYSTEM || mode == cmg_pkg::MODE_USER) |-> !cpu_grant)
        else $error("reserved eeprom reached");
    a_test_reach: assert property (mode == cmg_pkg::MODE_TEST && cpu_req.valid
        && cpu_req.space == cmg_pkg::SPACE_ROM && cpu_req.addr <= cmg_pkg::ROM_TEST_HI
        |-> cpu_grant)
        else $error("test mode rom denied");
    a_cop_confine: assert property (cop_req.valid && (cop_req.space == cmg_pkg::SPACE_ROM
        || cop_req.space == cmg_pkg::SPACE_SFR) |-> !cop_grant)
        else $error("coprocessor left its partitions");
endmodule : cmg_checker

bind cmg_mode_guard cmg_checker u_chk (.ref_clk, .reset, .boot_done, .ss_sel_we, .vec_req,
    .cpu_req, .cop_req, .mem_rdata, .mode, .vec_jump, .vec_addr, .cpu_grant, .cop_grant,
    .mem_cmd, .mem_from_cop, .cpu_rdata, .viol_exc);

// ---- verif/testbench.sv ----
// self-checking bench for the cpu mode memory guard
`timescale 1ns/1ps
module testbench;
    logic                  ref_clk = 1'b0;
    logic                  reset = 1'b1;
    logic                  test_fuse_blown = 1'b0;
    logic                  boot_done = 1'b0;
    logic                  ss_sel_we = 1'b0;
    logic [1:0]            ss_sel_val = 2'h0;
    logic                  ss_exit = 1'b0;
    logic                  drop_to_user = 1'b0;
    cmg_pkg::cmg_vec_req_t vec_req = '0;
    cmg_pkg::cmg_cfg_t     cfg = '0;
    cmg_pkg::cmg_access_t  cpu_req = '0;
    cmg_pkg::cmg_access_t  cop_req = '0;
    cmg_pkg::cmg_access_t  mem_cmd;
    cmg_pkg::cmg_mode_t    mode;
    logic [17:0]           vec_addr;
    logic [7:0]            mem_rdata;
    logic [7:0]            cpu_rdata;
    logic [7:0]            cop_rdata;
    logic                  vec_jump;
    logic                  cpu_grant;
    logic                  cop_grant;
    logic                  mem_from_cop;
    logic                  viol_exc;
    int                    failures = 0;
    int                    n_tests = 0;

    always #5 ref_clk = ~ref_clk;

    cmg_mode_guard dut (.ref_clk, .reset, .test_fuse_blown, .boot_done, .ss_sel_we,
        .ss_sel_val, .ss_exit, .drop_to_user, .vec_req, .cfg, .cpu_req, .cop_req,
        .mem_rdata, .mode, .vec_jump, .vec_addr, .cpu_grant, .cop_grant, .mem_cmd,
        .mem_from_cop, .cpu_rdata, .cop_rdata, .viol_exc);

    cmg_mem_model mem (.ref_clk, .mem_cmd, .mem_rdata);

    task automatic conclude;
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rst(logic fuse);
        @(posedge ref_clk);
        reset <= 1'b1;
        test_fuse_blown <= fuse;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("mode", cmg_pkg::MODE_BOOT, mode);
    endtask : rst

    // one-cycle pulse of {drop_to_user, ss_exit, ss_sel_we, boot_done}
    task automatic ctl(logic [3:0] p, logic [1:0] v);
        @(posedge ref_clk);
        {drop_to_user, ss_exit, ss_sel_we, boot_done} <= p;
        ss_sel_val <= v;
        @(posedge ref_clk);
        {drop_to_user, ss_exit, ss_sel_we, boot_done} <= 4'h0;
        #1;
    endtask : ctl

    task automatic cfgw(logic [2:0] s, logic [17:0] d);
        @(posedge ref_clk);
        cfg <= '{valid: 1'b1, sel: s, data: d};
        @(posedge ref_clk);
        cfg <= '0;
    endtask : cfgw

    task automatic acc(logic cop, cmg_pkg::cmg_space_t sp, logic [17:0] a, logic g);
        cmg_pkg::cmg_access_t r;
        r = '{valid: 1'b1, write: 1'b0, space: sp, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        if (cop)
            cop_req <= r;
        else
            cpu_req <= r;
        #1;
        chk("grant", g, cop ? cop_grant : cpu_grant);
        @(posedge ref_clk);
        cpu_req <= '0;
        cop_req <= '0;
        #1;
        chk("viol_exc", !cop && !g, viol_exc);
        chk("mem_cmd", g ? a : 18'h0, mem_cmd.addr);
        chk("mem_from_cop", cop && g, mem_from_cop);
        @(posedge ref_clk);
        #1;
        chk("rdata", g ? a[7:0] ^ 8'h5a : 8'h00, cop ? cop_rdata : cpu_rdata);
    endtask : acc

    task automatic vec(cmg_pkg::cmg_vec_kind_t k, logic [4:0] i, logic [17:0] exp);
        @(posedge ref_clk);
        vec_req <= '{valid: 1'b1, kind: k, index: i};
        @(posedge ref_clk);
        vec_req <= '0;
        #1;
        chk("vec_jump", 1'b1, vec_jump);
        chk("vec_addr", exp, vec_addr);
        chk("mode", cmg_pkg::MODE_SYSTEM, mode);
    endtask : vec

    task automatic sc_boot;
        rst(1'b1);
        ctl(4'h2, cmg_pkg::SS_SEL_TEST);
        chk("mode", cmg_pkg::MODE_BOOT, mode);
        acc(0, cmg_pkg::SPACE_ROM, 18'h28000, 1);
        acc(0, cmg_pkg::SPACE_ROM, 18'h00000, 0);
        acc(0, cmg_pkg::SPACE_RAM, 18'h0003f, 1);
        acc(0, cmg_pkg::SPACE_RAM, 18'h00040, 0);
        ctl(4'h1, 2'h0);
        chk("mode", cmg_pkg::MODE_SYSTEM, mode);
    endtask : sc_boot

    task automatic sc_sys;
        vec(cmg_pkg::VEC_IRQ, 5'h03, 18'h00118);
        vec(cmg_pkg::VEC_EXC, 5'h02, 18'h00010);
        acc(0, cmg_pkg::SPACE_ROM, 18'h27fff, 1);
        acc(0, cmg_pkg::SPACE_ROM, 18'h28000, 0);
        chk("vec_addr", 18'h0, vec_addr);
        acc(0, cmg_pkg::SPACE_EE, 18'h0007f, 0);
        acc(0, cmg_pkg::SPACE_EE, 18'h00080, 1);
        acc(0, cmg_pkg::SPACE_RAM, 18'h00dff, 1);
        acc(0, cmg_pkg::SPACE_RAM, 18'h017ff, 1);
        acc(0, cmg_pkg::SPACE_SFR, 18'h00020, 1);
    endtask : sc_sys

    task automatic sc_user;
        ctl(4'h8, 2'h0);
        chk("mode", cmg_pkg::MODE_USER, mode);
        acc(0, cmg_pkg::SPACE_SFR, 18'h00000, 1);
        acc(0, cmg_pkg::SPACE_SFR, 18'h00020, 0);
        chk("mode", cmg_pkg::MODE_SYSTEM, mode);
        cfgw(cmg_pkg::CFG_SFR_GRANT, 18'h00002);
        cfgw(cmg_pkg::CFG_RAM_HI, 18'h000ff);
        ctl(4'h8, 2'h0);
        acc(0, cmg_pkg::SPACE_SFR, 18'h00020, 1);
        acc(0, cmg_pkg::SPACE_RAM, 18'h000ff, 1);
        cfgw(cmg_pkg::CFG_RAM_HI, 18'h00000);
        acc(0, cmg_pkg::SPACE_RAM, 18'h000ff, 1);
        acc(0, cmg_pkg::SPACE_EE, 18'h00081, 0);
        for (int i = 0; i < 32; i++)
        begin
            ctl(4'h8, 2'h0);
            vec(cmg_pkg::VEC_SYS, 5'(i), 18'h00200 + 18'(i) * 18'h8);
        end
        cfgw(cmg_pkg::CFG_EE_LO, 18'h00081);
        cfgw(cmg_pkg::CFG_EE_HI, 18'h00090);
        cfgw(cmg_pkg::CFG_RAM_LO, 18'h00010);
        ctl(4'h8, 2'h0);
        acc(0, cmg_pkg::SPACE_EE, 18'h00081, 1);
        acc(0, cmg_pkg::SPACE_RAM, 18'h0000f, 0);
    endtask : sc_user

    task automatic sc_cop;
        acc(1, cmg_pkg::SPACE_RAM, 18'h00e00, 1);
        acc(1, cmg_pkg::SPACE_RAM, 18'h00000, 0);
        acc(1, cmg_pkg::SPACE_ROM, 18'h00000, 0);
        acc(1, cmg_pkg::SPACE_EE, 18'h00080, 1);
        acc(1, cmg_pkg::SPACE_EE, 18'h00000, 0);
    endtask : sc_cop

    task automatic sc_test;
        rst(1'b0);
        ctl(4'h1, 2'h0);
        chk("mode", cmg_pkg::MODE_TEST, mode);
        acc(0, cmg_pkg::SPACE_ROM, 18'h28000, 1);
        acc(0, cmg_pkg::SPACE_ROM, 18'h00000, 1);
        acc(0, cmg_pkg::SPACE_EE, 18'h00000, 1);
        ctl(4'h2, cmg_pkg::SS_SEL_BOOT);
        chk("mode", cmg_pkg::MODE_BOOT, mode);
        ctl(4'h2, cmg_pkg::SS_SEL_COMPAT);
        chk("mode", cmg_pkg::MODE_COMPAT, mode);
        acc(0, cmg_pkg::SPACE_ROM, 18'h2dfff, 1);
        acc(0, cmg_pkg::SPACE_ROM, 18'h27fff, 0);
        ctl(4'h2, cmg_pkg::SS_SEL_TEST);
        chk("mode", cmg_pkg::MODE_TEST, mode);
        ctl(4'h4, 2'h0);
        chk("mode", cmg_pkg::MODE_SYSTEM, mode);
    endtask : sc_test

    initial
    begin
        sc_boot();
        sc_sys();
        sc_user();
        sc_cop();
        sc_test();
        conclude();
    end
endmodule : testbench
